// [shared/tsi_pkg.sv]
/*
 Constants, types and the check-byte function of the temperature sensor
 two-wire slave. Assumes a 100 MHz system clock and an external converter
 that delivers finished samples as a one-cycle pulse with a 16-bit value.
*/
// Functional notes
// - START, address and direction open transactions
// - Address 1001 plus three fixed select bits
// - Write: address, pointer, high, low, all acked
// - Extra write bytes alternate high and low
// - Single data byte lands in upper half
// - Check-byte write needs multiple of three bytes
// - Second group check continues the running code
// - Read: pointer, repeated START, two bytes out
// - Check byte sent after second read byte
// - Pointer never increments, reads repeat register
// - Temperature update held off during temperature reads
// - Temperature two's complement, low bits zero
// - Format bit extends range to 128 degrees
// - Hysteresis above overtemp limit clamps to it
// - One-shot in shutdown converts then self-clears
// - One-shot ignored when not in shutdown
// - Config bit 4 high disables bus timeout
// - SCL low too long resets serial interface
// - Config bit 3 enables check bytes
// - Check byte is CRC-8 over whole message
// - Config bit 8 selects shutdown, bus stays live
package tsi_pkg;
    // --------------------------------------------------------------
    // Register pointers and reset values
    // --------------------------------------------------------------
    localparam logic [7:0] TSI_PTR_TEMP = 8'h00;
    localparam logic [7:0] TSI_PTR_CFG = 8'h01;
    localparam logic [7:0] TSI_PTR_HYST = 8'h02;
    localparam logic [7:0] TSI_PTR_TOS = 8'h03;
    localparam logic [15:0] TSI_RST_TEMP = 16'h0000;
    localparam logic [15:0] TSI_RST_CFG = 16'h0040;
    localparam logic [15:0] TSI_RST_HYST = 16'h4B00;
    localparam logic [15:0] TSI_RST_TOS = 16'h5000;
    localparam logic [15:0] TSI_CFG_WMASK = 16'h1BFF;
    // --------------------------------------------------------------
    // Configuration field positions
    // --------------------------------------------------------------
    localparam int TSI_B_ONESHOT = 0;
    localparam int TSI_B_RATE = 1;
    localparam int TSI_B_PEC = 3;
    localparam int TSI_B_TMODIS = 4;
    localparam int TSI_B_RES = 5;
    localparam int TSI_B_FMT = 7;
    localparam int TSI_B_SHDN = 8;
    // --------------------------------------------------------------
    // Bus constants and timing
    // --------------------------------------------------------------
    localparam logic [6:0] TSI_ADDR_BASE = 7'h48;
    localparam logic [7:0] TSI_CRC_POLY = 8'h07;
    localparam int TSI_TIMEOUT_MS = 30;
    localparam int TSI_CLK_MHZ = 100;
    localparam int TSI_TIMEOUT_CYC = TSI_TIMEOUT_MS * 1000 * TSI_CLK_MHZ;
    localparam logic [2:0] TSI_LINKRST_CYC = 3'h4;
    localparam logic [3:0] TSI_ACK_SLOT = 4'h8;
    localparam logic [3:0] TSI_LAST_BIT = 4'h7;

    typedef enum logic [1:0] {
        LK_ADDR = 2'b00,
        LK_WRITE = 2'b01,
        LK_READ = 2'b10,
        LK_IDLE = 2'b11
    } tsi_link_type;

    typedef enum logic [2:0] {
        TR_IDLE = 3'b000,
        TR_ADDR = 3'b001,
        TR_PTR = 3'b010,
        TR_DATA = 3'b011,
        TR_READ = 3'b100,
        TR_SKIP = 3'b101
    } tsi_trans_type;

    // Finished sample from the converter
    typedef struct packed {
        logic done;
        logic [15:0] value;
    } tsi_conv_type;

    // CRC-8 step over one byte, most significant bit first
    function automatic logic [7:0] tsi_crc8(input logic [7:0] crc,
                                            input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ TSI_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : tsi_crc8
endpackage : tsi_pkg

// [hdl/tsi_slave.sv]
/*
 Two-wire slave and register set of the temperature sensor. The bit
 engine runs on SCL; framing, registers and timeout run on clk.
 Assumes SDA and SCL arrive from open-drain wires resolved outside, and
 that SCL is slow against clk (tLOW and tHIGH of many clk periods).
*/
`timescale 1ns/1ps
module tsi_slave #(
    parameter logic [2:0] ADDR_SEL = 3'h0,
    parameter int unsigned TIMEOUT_CYCLES = tsi_pkg::TSI_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOutEnN,
    input tsi_pkg::tsi_conv_type conv,
    output logic convStart,
    output logic shutdownMode,
    output logic extFormat,
    output logic [1:0] resolution,
    output logic [1:0] rateSel,
    output logic [15:0] tosLimit,
    output logic [15:0] hystLimit
);
    import tsi_pkg::*;

    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES);
    localparam logic [6:0] DEV_ADDR = {TSI_ADDR_BASE[6:3], ADDR_SEL};

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    logic linkRst, linkRst_r, ackDrv_r, rxTgl_r, drive;
    logic startEv, stopEv, byteEv, timeoutEv, commit, pecOn;
    logic gotHi_r, gotLo_r, pecBad_r, readBusy_r;
    logic pendValid_r, convStart_r;
    logic [1:0] txIdx_r, pecLk_r, pos_r;
    logic [2:0] rstCnt_r, sclS_r, sdaS_r, rxTglS_r;
    logic [3:0] cnt_r;
    logic [6:0] shift_r;
    logic [7:0] rxByte_r, txByte, ptr_r, crc_r, crcRd;
    logic [7:0] stHi_r, stLo_r, txHi_r, txLo_r, txPec_r;
    logic [15:0] cfg_r, tos_r, hyst_r, temp_r, pend_r;
    logic [15:0] tosLimit_r, hystLimit_r, cfgNew, rdWord;
    logic [TO_W-1:0] toCnt_r;
    tsi_link_type mode_r;
    tsi_trans_type tr_r;

    // Zero the bits below the selected resolution
    function automatic logic [15:0] res_mask(input logic [1:0] res,
                                             input logic ext);
        logic [15:0] m;
        case (res)
            2'h0: m = 16'hFF00;
            2'h1: m = 16'hFF80;
            2'h2: m = 16'hFFC0;
            default: m = 16'hFFF0;
        endcase
        return ext ? (m | (m >> 1)) : m;
    endfunction : res_mask

    // Register contents seen through a pointer
    function automatic logic [15:0] reg_read(input logic [7:0] p,
                                             input logic [15:0] t,
                                             input logic [15:0] c,
                                             input logic [15:0] h,
                                             input logic [15:0] o);
        case (p)
            TSI_PTR_TEMP: return t;
            TSI_PTR_CFG: return c;
            TSI_PTR_HYST: return h;
            TSI_PTR_TOS: return o;
            default: return 16'h0000;
        endcase
    endfunction : reg_read

    // --------------------------------------------------------------
    // Link domain: bit engine on SCL
    // --------------------------------------------------------------
    assign linkRst = rst | linkRst_r;
    assign pecOn = cfg_r[TSI_B_PEC];

    // Check-enable level brought onto SCL
    always_ff @(posedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            pecLk_r <= 2'h0;
        end else begin
            pecLk_r <= {pecLk_r[0], pecOn};
        end
    end

    // Bit counter, address match, ack decision and byte index
    always_ff @(posedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            cnt_r <= 4'h0;
            shift_r <= 7'h00;
            mode_r <= LK_ADDR;
            ackDrv_r <= 1'b0;
            txIdx_r <= 2'h0;
        end else if (cnt_r == TSI_ACK_SLOT) begin
            cnt_r <= 4'h0;
            ackDrv_r <= 1'b0;
            if (mode_r == LK_READ && !ackDrv_r) begin
                if (sdaIn) begin
                    mode_r <= LK_IDLE;
                end
                if (pecLk_r[1]) begin
                    txIdx_r <= (txIdx_r == 2'h2) ? 2'h0 : txIdx_r + 2'h1;
                end else begin
                    txIdx_r <= {1'b0, ~txIdx_r[0]};
                end
            end
        end else begin
            cnt_r <= cnt_r + 4'h1;
            shift_r <= {shift_r[5:0], sdaIn};
            if (cnt_r == TSI_LAST_BIT) begin
                case (mode_r)
                    LK_ADDR: begin
                        ackDrv_r <= (shift_r == DEV_ADDR);
                        txIdx_r <= 2'h0;
                        if (shift_r != DEV_ADDR) begin
                            mode_r <= LK_IDLE;
                        end else if (sdaIn) begin
                            mode_r <= LK_READ;
                        end else begin
                            mode_r <= LK_WRITE;
                        end
                    end
                    LK_WRITE: ackDrv_r <= 1'b1;
                    default: ackDrv_r <= 1'b0;
                endcase
            end
        end
    end

    // Received byte and its toggle survive the framing reset
    always_ff @(posedge sclClk or posedge rst) begin
        if (rst) begin
            rxByte_r <= 8'h00;
            rxTgl_r <= 1'b0;
        end else if (cnt_r == TSI_LAST_BIT &&
                     (mode_r == LK_ADDR || mode_r == LK_WRITE)) begin
            rxByte_r <= {shift_r, sdaIn};
            rxTgl_r <= ~rxTgl_r;
        end
    end

    // Send order high, low, then check byte when enabled
    always_comb begin
        case (txIdx_r)
            2'h0: txByte = txHi_r;
            2'h1: txByte = txLo_r;
            default: txByte = txPec_r;
        endcase
        drive = (cnt_r == TSI_ACK_SLOT && ackDrv_r) ||
                (mode_r == LK_READ && cnt_r < TSI_ACK_SLOT &&
                 !txByte[~cnt_r[2:0]]);
    end

    // SDA changes only while SCL is low
    always_ff @(negedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            sdaOutEnN <= 1'b1;
        end else begin
            sdaOutEnN <= ~drive;
        end
    end
    assign sdaOut = 1'b0;
    // --------------------------------------------------------------
    // Clock domain: framing, timeout and link reset
    // --------------------------------------------------------------
    // Pin and toggle synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclS_r <= 3'h7;
            sdaS_r <= 3'h7;
            rxTglS_r <= 3'h0;
        end else begin
            sclS_r <= {sclS_r[1:0], sclClk};
            sdaS_r <= {sdaS_r[1:0], sdaIn};
            rxTglS_r <= {rxTglS_r[1:0], rxTgl_r};
        end
    end

    assign startEv = sclS_r[1] && sclS_r[2] && sdaS_r[2] && !sdaS_r[1];
    assign stopEv = sclS_r[1] && sclS_r[2] && !sdaS_r[2] && sdaS_r[1];
    assign byteEv = rxTglS_r[2] ^ rxTglS_r[1];
    assign timeoutEv = (toCnt_r == TO_LAST);

    // SCL low-time counter, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toCnt_r <= '0;
        end else if (cfg_r[TSI_B_TMODIS] || sclS_r[1]) begin
            toCnt_r <= '0;
        end else if (!timeoutEv) begin
            toCnt_r <= toCnt_r + TO_W'(1);
        end
    end

    // Framing reset of the bit engine, stretched a few cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rstCnt_r <= 3'h0;
            linkRst_r <= 1'b0;
        end else begin
            linkRst_r <= startEv || stopEv || timeoutEv || rstCnt_r != 3'h0;
            if (startEv || stopEv || timeoutEv) begin
                rstCnt_r <= TSI_LINKRST_CYC;
            end else if (rstCnt_r != 3'h0) begin
                rstCnt_r <= rstCnt_r - 3'h1;
            end
        end
    end

    assign commit = (stopEv || startEv || timeoutEv) && !timeoutEv &&
                    tr_r == TR_DATA &&
                    (pecOn ? (pos_r == 2'h0 && gotLo_r && !pecBad_r)
                           : gotHi_r);
    assign rdWord = reg_read(ptr_r, temp_r, cfg_r, hyst_r, tos_r);
    assign crcRd = tsi_crc8(crc_r, rxByte_r);

    // Transaction tracking, staging and running check code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tr_r <= TR_IDLE;
            ptr_r <= 8'h00;
            crc_r <= 8'h00;
            pos_r <= 2'h0;
            gotHi_r <= 1'b0;
            gotLo_r <= 1'b0;
            pecBad_r <= 1'b0;
            stHi_r <= 8'h00;
            stLo_r <= 8'h00;
            txHi_r <= 8'h00;
            txLo_r <= 8'h00;
            txPec_r <= 8'h00;
            readBusy_r <= 1'b0;
        end else if (timeoutEv || stopEv) begin
            tr_r <= TR_IDLE;
            readBusy_r <= 1'b0;
        end else if (startEv) begin
            tr_r <= TR_ADDR;
            readBusy_r <= 1'b0;
        end else if (byteEv) begin
            case (tr_r)
                TR_ADDR: begin
                    if (rxByte_r[7:1] != DEV_ADDR) begin
                        tr_r <= TR_SKIP;
                    end else if (rxByte_r[0]) begin
                        tr_r <= TR_READ;
                        txHi_r <= rdWord[15:8];
                        txLo_r <= rdWord[7:0];
                        txPec_r <= tsi_crc8(tsi_crc8(crcRd, rdWord[15:8]),
                                            rdWord[7:0]);
                        readBusy_r <= (ptr_r == TSI_PTR_TEMP);
                    end else begin
                        tr_r <= TR_PTR;
                        crc_r <= tsi_crc8(8'h00, rxByte_r); // Fresh code
                    end
                end
                TR_PTR: begin
                    tr_r <= TR_DATA;
                    ptr_r <= rxByte_r;
                    crc_r <= crcRd;
                    pos_r <= 2'h0;
                    gotHi_r <= 1'b0;
                    gotLo_r <= 1'b0;
                    pecBad_r <= 1'b0;
                end
                TR_DATA: begin
                    crc_r <= crcRd;
                    case (pos_r)
                        2'h0: begin
                            stHi_r <= rxByte_r;
                            gotHi_r <= 1'b1;
                            pos_r <= 2'h1;
                        end
                        2'h1: begin
                            stLo_r <= rxByte_r;
                            gotLo_r <= 1'b1;
                            pos_r <= pecOn ? 2'h2 : 2'h0;
                        end
                        default: begin
                            if (rxByte_r != crc_r) begin
                                pecBad_r <= 1'b1;
                            end
                            pos_r <= 2'h0;
                        end
                    endcase
                end
                default: tr_r <= tr_r;
            endcase
        end
    end
    // --------------------------------------------------------------
    // Register set
    // --------------------------------------------------------------
    assign cfgNew = {stHi_r, gotLo_r ? stLo_r : cfg_r[7:0]};

    // Configuration with one-shot handling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_r <= TSI_RST_CFG;
            convStart_r <= 1'b0;
        end else begin
            convStart_r <= 1'b0;
            if (commit && ptr_r == TSI_PTR_CFG) begin
                cfg_r <= cfgNew & TSI_CFG_WMASK;
                cfg_r[TSI_B_ONESHOT] <= cfgNew[TSI_B_ONESHOT] &&
                                        cfg_r[TSI_B_SHDN];
                convStart_r <= cfgNew[TSI_B_ONESHOT] && cfg_r[TSI_B_SHDN];
            end else if (conv.done) begin
                cfg_r[TSI_B_ONESHOT] <= 1'b0;
            end
        end
    end

    // Threshold registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tos_r <= TSI_RST_TOS;
            hyst_r <= TSI_RST_HYST;
        end else if (commit && ptr_r == TSI_PTR_TOS) begin
            tos_r <= {stHi_r, gotLo_r ? stLo_r : tos_r[7:0]};
        end else if (commit && ptr_r == TSI_PTR_HYST) begin
            hyst_r <= {stHi_r, gotLo_r ? stLo_r : hyst_r[7:0]};
        end
    end

    // Temperature with hold-off while a read of the temperature register is under way
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            temp_r <= TSI_RST_TEMP;
            pend_r <= TSI_RST_TEMP;
            pendValid_r <= 1'b0;
        end else if (conv.done && readBusy_r) begin
            pend_r <= conv.value & res_mask(cfg_r[TSI_B_RES +: 2],
                                            cfg_r[TSI_B_FMT]);
            pendValid_r <= 1'b1;
        end else if (conv.done) begin
            temp_r <= conv.value & res_mask(cfg_r[TSI_B_RES +: 2],
                                            cfg_r[TSI_B_FMT]);
            pendValid_r <= 1'b0;
        end else if (pendValid_r && !readBusy_r) begin
            temp_r <= pend_r;
            pendValid_r <= 1'b0;
        end
    end

    // Effective limits for the comparator outside
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tosLimit_r <= TSI_RST_TOS;
            hystLimit_r <= TSI_RST_HYST;
        end else begin
            tosLimit_r <= tos_r;
            hystLimit_r <= ($signed(hyst_r) > $signed(tos_r)) ? tos_r : hyst_r;
        end
    end

    // Mode outputs straight from configuration, then the one-shot pulse and the limits from their registers
    // shutdown leaves bus active
    assign shutdownMode = cfg_r[TSI_B_SHDN];
    assign extFormat = cfg_r[TSI_B_FMT];
    assign resolution = cfg_r[TSI_B_RES +: 2];
    assign rateSel = cfg_r[TSI_B_RATE +: 2];
    assign convStart = convStart_r;
    assign tosLimit = tosLimit_r;
    assign hystLimit = hystLimit_r;
endmodule : tsi_slave

// [tb/tsi_slave_asserts.sv]
/* Port checker of the two-wire slave.
 Assumes it is bound onto every tsi_slave instance. */
`timescale 1ns/1ps
module tsi_slave_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclClk,
    input wire logic sdaOut,
    input wire logic sdaOutEnN,
    input wire logic convStart,
    input wire logic shutdownMode,
    input wire logic extFormat,
    input wire logic [15:0] tosLimit,
    input wire logic [15:0] hystLimit
);
    // ----------------------------------------
    // Bus and register relations
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_sda_open_drain: assert property (sdaOut == 1'b0)
        else $error("sda driven high");
    a_drive_scl_low: assert property ($fell(sdaOutEnN) |-> !sclClk)
        else $error("sda taken while scl high");
    a_drive_holds: assert property
        ($fell(sdaOutEnN) |=> !sdaOutEnN [*4])
        else $error("sda drive glitch");
    a_cfg_at_stop: assert property
        ($changed({shutdownMode, extFormat, tosLimit}) |-> sclClk)
        else $error("commit while scl low");
    a_hyst_clamp: assert property
        ($signed(hystLimit) <= $signed(tosLimit))
        else $error("hysteresis above limit");
    a_oneshot_gate: assert property
        (convStart |-> $past(shutdownMode))
        else $error("one-shot outside shutdown");
    a_oneshot_pulse: assert property (convStart |=> !convStart)
        else $error("one-shot pulse too long");
    a_reset_release: assert property
        (disable iff (1'b0) rst |-> sdaOutEnN && !convStart)
        else $error("active during reset");
    c_ack: cover property ($fell(sdaOutEnN));
    c_shot: cover property (convStart);
    c_tos: cover property ($changed(tosLimit));
endmodule : tsi_slave_asserts

bind tsi_slave tsi_slave_asserts chk (.clk(clk), .rst(rst),
    .sclClk(sclClk), .sdaOut(sdaOut), .sdaOutEnN(sdaOutEnN),
    .convStart(convStart), .shutdownMode(shutdownMode),
    .extFormat(extFormat), .tosLimit(tosLimit), .hystLimit(hystLimit));

// [tb/tsi_master.sv]
/* Bus master model: drives SCL and pulls SDA low.
 Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
module tsi_master (
    output logic scl,
    output logic sdaEnN,
    input wire logic sda
);
    logic lclk = 1'b0;
    // ----------------------------------------
    // Link timebase of 12 ns, SCL idles high
    // ----------------------------------------
    always #6 lclk = ~lclk;
    initial scl = 1'b1;
    initial sdaEnN = 1'b1;
    task automatic ph(input int n);
        repeat (n) @(posedge lclk);
    endtask : ph
    // One bit, data set while SCL low
    task automatic bitX(input logic b, output logic q);
        ph(2);
        sdaEnN <= b;
        ph(8);
        scl <= 1'b1;
        ph(10);
        q = sda;
        scl <= 1'b0;
    endtask : bitX
    // START as 10, STOP as 01
    task automatic cond(input logic [1:0] s);
        ph(2);
        sdaEnN <= s[1];
        ph(8);
        scl <= 1'b1;
        ph(10);
        sdaEnN <= s[0];
        ph(10);
        scl <= s[0];
    endtask : cond
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bitX(d[i], q[i]);
    endtask : xfer
endmodule : tsi_master

// [tb/tsi_slave_tb.sv]
/* Self-checking bench of the two-wire slave.
 Assumes tsi_master drives the bus and SDA has a pull-up. */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errCount++; \
$display("ERROR %0t: got %h want %h", $time, g, e); end end
module tsi_slave_tb;
    import tsi_pkg::*;
    localparam logic [7:0] AW = 8'h90;
    localparam logic [7:0] AR = 8'h91;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclClk, mEnN, sdaOut, sdaOutEnN, convStart, shutdownMode;
    logic extFormat;
    logic [1:0] resolution, rateSel;
    logic [15:0] tosLimit, hystLimit;
    tsi_conv_type conv = '0;
    logic [8:0] r;
    logic [47:0] v;
    int errCount = 0;
    int compares = 0;
    int starts = 0;
    wire logic sdaIn = mEnN & (sdaOutEnN | sdaOut);
    // ----------------------------------------
    // Clock, pulse counter and instances
    // ----------------------------------------
    always #5 clk = ~clk;
    always @(posedge clk) if (convStart === 1'b1) starts++;
    tsi_slave #(.TIMEOUT_CYCLES(2000)) DUT (.clk(clk), .rst(rst),
        .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOutEnN(sdaOutEnN), .conv(conv), .convStart(convStart),
        .shutdownMode(shutdownMode), .extFormat(extFormat),
        .resolution(resolution), .rateSel(rateSel), .tosLimit(tosLimit),
        .hystLimit(hystLimit));
    tsi_master M (.scl(sclClk), .sdaEnN(mEnN), .sda(sdaIn));
    function automatic logic [7:0] crc(logic [7:0] c, logic [7:0] b);
        c = c ^ b;
        for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ {5'h00, {3{c[7]}}};
        return c;
    endfunction : crc
    task automatic send(input logic [7:0] b);
        M.xfer({b, 1'b1}, r);
        `CHK(r[0], 1'b0)
    endtask : send
    task automatic pulse(input logic [15:0] t);
        @(posedge clk);
        conv <= {1'b1, t};
        @(posedge clk);
        conv <= '0;
    endtask : pulse
    task automatic wr(input logic [7:0] p, input int n, input logic [47:0] d);
        M.cond(2'b10);
        send(AW);
        send(p);
        for (int k = n - 1; k >= 0; k--) send(d[8*k +: 8]);
        M.cond(2'b01);
    endtask : wr
    task automatic rd(input logic [7:0] p, input int n,
                      input logic h = 1'b0, input logic [15:0] t = 16'h0);
        M.cond(2'b10);
        send(AW);
        send(p);
        M.cond(2'b10);
        send(AR);
        if (h) pulse(t);
        v = '0;
        for (int k = 1; k <= n; k++) begin
            M.xfer({8'hFF, 1'(k == n)}, r);
            v = {v[39:0], r[8:1]};
        end
        M.cond(2'b01);
    endtask : rd
    task automatic t_reset;
        logic [15:0] rv [4] = '{16'h0000, 16'h0040, 16'h4B00, 16'h5000};
        for (int i = 0; i < 4; i++) begin
            rd(8'(i), 4);
            `CHK(v[31:0], {rv[i], rv[i]})
        end
        $display("t_reset done");
    endtask : t_reset
    task automatic t_addr;
        for (int i = 0; i < 9; i++) begin
            M.cond(2'b10);
            M.xfer({7'h48 + 7'(i), 2'b01}, r);
            `CHK(r[0], 1'(i != 0))
            M.xfer(9'h1FF, r);
            `CHK(r, {8'hFF, 1'(i != 0)})
            M.cond(2'b01);
        end
        $display("t_addr done");
    endtask : t_addr
    task automatic t_write;
        wr(8'h03, 2, 48'h55AA);
        `CHK(tosLimit, 16'h55AA)
        wr(8'h03, 1, 48'h12);
        `CHK(tosLimit, 16'h12AA)
        wr(8'h03, 4, 48'h11223344);
        `CHK(tosLimit, 16'h3344)
        wr(8'h02, 2, 48'h7F00);
        `CHK(hystLimit, 16'h3344)
        wr(8'h00, 2, 48'h7FFF);
        rd(8'h00, 2);
        `CHK(v[15:0], 16'h0000)
        $display("t_write done");
    endtask : t_write
    task automatic t_shot;
        wr(8'h01, 2, 48'h0041);
        `CHK(starts, 0)
        wr(8'h01, 2, 48'h01C6);
        `CHK({shutdownMode, extFormat}, 2'b11)
        `CHK({resolution, rateSel}, 4'hB)
        wr(8'h01, 2, 48'h0141);
        `CHK(starts, 1)
        pulse(16'hFFFF);
        rd(8'h01, 2);
        `CHK(v[15:0], 16'h0140)
        rd(8'h00, 2, 1'b1, 16'h1230);
        `CHK(v[15:0], 16'hFFC0)
        rd(8'h00, 2);
        `CHK(v[15:0], 16'h1200)
        $display("t_shot done");
    endtask : t_shot
    task automatic t_pec;
        logic [7:0] c;
        wr(8'h01, 2, 48'h0008);
        c = crc(crc(crc(crc(8'h00, AW), 8'h03), 8'h12), 8'h34);
        wr(8'h03, 3, {24'h0, 16'h1234, c});
        `CHK(tosLimit, 16'h1234)
        wr(8'h03, 3, {24'h0, 16'h5678, c});
        `CHK(tosLimit, 16'h1234)
        wr(8'h03, 2, 48'h5678);
        `CHK(tosLimit, 16'h1234)
        wr(8'h03, 6, {16'h1234, c, 16'hABCD,
                      crc(crc(crc(c, c), 8'hAB), 8'hCD)});
        `CHK(tosLimit, 16'hABCD)
        rd(8'h03, 3);
        c = crc(crc(crc(crc(crc(8'h00, AW), 8'h03), AR), 8'hAB), 8'hCD);
        `CHK(v[23:0], {16'hABCD, c})
        $display("t_pec done");
    endtask : t_pec
    task automatic t_tmo;
        logic b;
        M.cond(2'b10);
        for (int i = 7; i >= 0; i--) M.bitX(AW[i], b);
        M.ph(20);
        `CHK(sdaOutEnN, 1'b0)
        M.ph(2100);
        `CHK(sdaOutEnN, 1'b1)
        M.cond(2'b01);
        $display("t_tmo done");
    endtask : t_tmo
    task automatic testDone;
        $display("TB: %0d compares, %0d errors", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : testDone
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_addr();
        t_write();
        t_shot();
        t_pec();
        t_tmo();
        testDone();
    end
    // Watchdog cuts a hang short
    initial begin
        #800us;
        errCount++;
        testDone();
    end
endmodule : tsi_slave_tb
